/* servo_cmd_regs.svh */
/*
  Offsets, codes, field positions and reset values of the servo packet command unit.
  Assumes inclusion by bare name from the command unit and the testbench.
*/
`ifndef SERVO_CMD_REGS_SVH
`define SERVO_CMD_REGS_SVH
// ----------------------------------------------------------------
// packet framing
// ----------------------------------------------------------------
`define PKT_HEADER 8'hFF
`define PKT_BROADCAST_ID 8'hFE
`define OP_READ 8'h02
`define OP_WRITE 8'h03
`define OP_DEFER 8'h04
`define OP_TRIGGER 8'h05
`define LEN_READ 8'h04
`define LEN_TRIGGER 8'h02
`define ERR_INSTR_BIT 6
// ----------------------------------------------------------------
// table offsets, limits, reset values and depth
// ----------------------------------------------------------------
`define ADR_ID 8'h03
`define ADR_CW_LIMIT_L 8'h06
`define ADR_CW_LIMIT_H 8'h07
`define ADR_CCW_LIMIT_L 8'h08
`define ADR_CCW_LIMIT_H 8'h09
`define ADR_GOAL_L 8'h1E
`define ADR_GOAL_H 8'h1F
`define ADR_SPEED_L 8'h20
`define ADR_SPEED_H 8'h21
`define ADR_LOAD_L 8'h28
`define ADR_LOAD_H 8'h29
`define ADR_VOLTAGE 8'h2A
`define ADR_TEMPERATURE 8'h2B
`define ADR_DEFER_PEND 8'h2C
`define ADR_MOVING 8'h2E
`define ADR_LOCK 8'h2F
`define ADR_TAPER_L 8'h30
`define ADR_TAPER_H 8'h31
`define ADR_LOCK_LO 8'h18
`define ADR_LOCK_HI 8'h23
`define TAPER_RESET 16'h0020
`define TAPER_MAX 16'h03FF
`define TORQUE_FULL 10'h3FF
`define ID_RESET 8'h01
`define TABLE_DEPTH 64
`endif

/* servo_cmd_pkg.sv */
/*
  Types shared by the servo packet command unit.
  Assumes the constants header sits in the same folder.
*/
package servo_cmd_pkg;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } byteStream_t;

  typedef struct packed {
    logic dir;
    logic [9:0] magnitude;
  } torqueCmd_t;

  typedef enum {
    ST_HDR1, ST_HDR2, ST_ID, ST_LEN, ST_OP, ST_PARAM, ST_CHK,
    ST_EXEC, ST_TX_HDR1, ST_TX_HDR2, ST_TX_ID, ST_TX_LEN, ST_TX_ERR,
    ST_TX_DATA, ST_TX_CHK
  } cmdState_t;
endpackage

/* two_entry_buffer.sv */
/*
  Two-entry valid/ready buffer for the outgoing status byte stream.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module two_entry_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [$clog2(DEPTH):0] count;
    logic [$clog2(DEPTH)-1:0] rdPtr;
    logic [$clog2(DEPTH)-1:0] wrPtr;
  } bufState_t;

  bufState_t state_r;
  bufState_t state_nxt;
  logic push;
  logic pop;

  assign inReady = (state_r.count != ($clog2(DEPTH)+1)'(DEPTH));
  assign outValid = (state_r.count != '0);
  assign outData = state_r.mem[state_r.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    state_nxt = state_r;
    if (push) begin
      state_nxt.mem[state_r.wrPtr] = inData;
      state_nxt.wrPtr = state_r.wrPtr + 1'b1;
    end
    if (pop) begin
      state_nxt.rdPtr = state_r.rdPtr + 1'b1;
    end
    state_nxt.count = state_r.count + ($clog2(DEPTH)+1)'(push) - ($clog2(DEPTH)+1)'(pop);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
endmodule // two_entry_buffer

/* servo_packet_command_unit.sv */
/*
  Packet command interpreter of a bus servo: parses instruction packets, runs
  table read, immediate write, deferred write and trigger, and emits status packets.
  Assumes a byte-wide receive strobe from a serial front end and a transmitter that
  accepts status bytes with valid/ready; sensor readings arrive as plain inputs.
*/
//
// Function
// - voltage byte reads ten times supply volts
// - temperature byte is plain degrees Celsius
// - pending flag set on defer, cleared by trigger
// - motion flag high until target reached, always low in endless turn
// - lock limits writes to 24..35, sticky
// - taper torque floor, reset 32, max 1023
// - both travel limits zero selects endless turn
// - endless turn: speed field is signed torque
// - torque magnitude scales linearly to full torque
// - stalled at full torque reports load 1023
// - execute each accepted packet, answer non-broadcast ones with status
// - packet: two headers, id, length, op, params, check
// - read returns count bytes from start address
// - status: headers, id, length, error, data, check
// - immediate write stores bytes from start address
// - writing address 3 changes own id
// - accept broadcast id, never answer it
// - deferred write buffered, table untouched
// - trigger executes the buffered write
// - bad opcode or idle trigger flags error bit 6
`timescale 1ns/1ns
`include "servo_cmd_regs.svh"
module servo_packet_command_unit
  import servo_cmd_pkg::*;
#(
  parameter int PARAM_DEPTH = 16,
  parameter int TABLE_DEPTH = `TABLE_DEPTH
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [7:0] supplyVoltageTenths,
  input wire logic [7:0] temperatureCelsius,
  input wire logic [9:0] presentPosition,
  input wire logic stalledAtFullTorque,
  input wire logic [10:0] measuredLoad,
  output logic endlessTurn,
  output torqueCmd_t torqueCommand,
  output logic [9:0] goalPosition,
  output logic [15:0] taperTorque,
  output logic motionActive
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cmdState_t st;
    logic [7:0] pktId;
    logic [7:0] pktLen;
    logic [7:0] pktOp;
    logic [7:0] sum;
    logic [7:0] idx;
    logic [PARAM_DEPTH-1:0][7:0] params;
    logic [PARAM_DEPTH-1:0][7:0] deferBuf;
    logic [7:0] deferLen;
    logic deferPending;
    logic lock;
    logic [7:0] ownId;
    logic [7:0] errByte;
    logic [7:0] txCount;
    logic [7:0] txIdx;
    logic [7:0] txSum;
    logic [7:0] bufData;
    logic bufValid;
    logic [TABLE_DEPTH-1:0][7:0] cells;
    logic endless;
    torqueCmd_t torque;
    logic moving;
    logic [7:0] txOut;
    logic txOutValid;
  } unitState_t;

  unitState_t s_r;
  unitState_t s_nxt;
  logic bufReady;
  logic [7:0] sendByte;
  logic [7:0] bufOutData;
  logic bufOutValid;
  logic bufOutReady;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] checkOf(input logic [7:0] sum);
    checkOf = ~sum;
  endfunction

  function automatic logic writeAllowed(input logic locked, input logic [7:0] adr);
    writeAllowed = !locked || (adr >= `ADR_LOCK_LO && adr <= `ADR_LOCK_HI);
  endfunction

  function automatic logic [9:0] goalOf(input unitState_t s);
    goalOf = {s.cells[`ADR_GOAL_H][1:0], s.cells[`ADR_GOAL_L]};
  endfunction

  function automatic logic [15:0] taperOf(input unitState_t s);
    taperOf = {s.cells[`ADR_TAPER_H], s.cells[`ADR_TAPER_L]};
  endfunction

  // sensor and status addresses answer from live state, not the array
  function automatic logic [7:0] readTable(input unitState_t s, input logic [7:0] adr,
                                           input logic [7:0] volt, input logic [7:0] temp,
                                           input logic [9:0] pos, input logic stall,
                                           input logic [10:0] load);
    logic [10:0] ld;
    ld = stall ? {load[10], `TORQUE_FULL} : load;
    case (adr)
      `ADR_ID: readTable = s.ownId;
      8'h24: readTable = pos[7:0];
      8'h25: readTable = {6'h00, pos[9:8]};
      `ADR_LOAD_L: readTable = ld[7:0];
      `ADR_LOAD_H: readTable = {5'h00, ld[10:8]};
      `ADR_VOLTAGE: readTable = volt;
      `ADR_TEMPERATURE: readTable = temp;
      `ADR_DEFER_PEND: readTable = {7'h00, s.deferPending};
      `ADR_MOVING: readTable = {7'h00, s.moving};
      `ADR_LOCK: readTable = {7'h00, s.lock};
      default: readTable = (32'(adr) < TABLE_DEPTH) ? s.cells[adr[5:0]] : 8'h00;
    endcase
  endfunction

  // one byte store; read-only cells ignore the write
  function automatic unitState_t storeByte(input unitState_t s, input logic [7:0] adr,
                                           input logic [7:0] val);
    unitState_t r;
    logic [15:0] taper;
    r = s;
    if (writeAllowed(s.lock, adr) && 32'(adr) < TABLE_DEPTH) begin
      case (adr)
        `ADR_ID: r.ownId = val;
        `ADR_VOLTAGE, `ADR_TEMPERATURE, `ADR_DEFER_PEND, `ADR_MOVING: r = r;
        // the lock only ever sets; nothing short of reset clears it
        `ADR_LOCK: r.lock = s.lock | val[0];
        `ADR_TAPER_L, `ADR_TAPER_H: begin
          taper = taperOf(s);
          if (adr == `ADR_TAPER_L) taper[7:0] = val;
          else taper[15:8] = val;
          if (taper > `TAPER_MAX) taper = `TAPER_MAX;
          r.cells[`ADR_TAPER_L] = taper[7:0];
          r.cells[`ADR_TAPER_H] = taper[15:8];
        end
        default: r.cells[adr[5:0]] = val;
      endcase
    end
    storeByte = r;
  endfunction

  function automatic unitState_t runWrite(input unitState_t s, input logic [7:0] len,
                                          input logic [PARAM_DEPTH-1:0][7:0] p);
    unitState_t r;
    r = s;
    for (int i = 1; i < PARAM_DEPTH; i++) begin
      if (8'(i) < len - 8'd2) begin
        r = storeByte(r, p[0] + 8'(i - 1), p[i]);
      end
    end
    runWrite = r;
  endfunction

  // ----------------------------------------------------------------
  // status byte selection
  // ----------------------------------------------------------------
  always_comb begin
    sendByte = 8'h00;
    case (s_r.st)
      ST_TX_HDR1, ST_TX_HDR2: sendByte = `PKT_HEADER;
      ST_TX_ID: sendByte = s_r.ownId;
      ST_TX_LEN: sendByte = s_r.txCount + 8'd2;
      ST_TX_ERR: sendByte = s_r.errByte;
      ST_TX_DATA: sendByte = readTable(s_r, s_r.params[0] + s_r.txIdx, supplyVoltageTenths,
                                       temperatureCelsius, presentPosition,
                                       stalledAtFullTorque, measuredLoad);
      ST_TX_CHK: sendByte = checkOf(s_r.txSum);
      default: sendByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (s_r.bufValid && bufReady) s_nxt.bufValid = 1'b0;
    // output stage: the transmitter only ever sees flop outputs
    if (s_r.txOutValid && txReady) s_nxt.txOutValid = 1'b0;
    if (bufOutValid && bufOutReady) begin
      s_nxt.txOut = bufOutData;
      s_nxt.txOutValid = 1'b1;
    end
    case (s_r.st)
      ST_HDR1: if (rxValid) s_nxt.st = (rxData == `PKT_HEADER) ? ST_HDR2 : ST_HDR1;
      ST_HDR2: if (rxValid) s_nxt.st = (rxData == `PKT_HEADER) ? ST_ID : ST_HDR1;
      ST_ID: if (rxValid) begin
        // a third header byte is tolerated as line idle
        if (rxData != `PKT_HEADER) begin
          s_nxt.pktId = rxData;
          s_nxt.sum = rxData;
          s_nxt.st = ST_LEN;
        end
      end
      ST_LEN: if (rxValid) begin
        s_nxt.pktLen = rxData;
        s_nxt.sum = s_r.sum + rxData;
        s_nxt.st = (rxData < 8'd2 || 32'(rxData) > PARAM_DEPTH + 2) ? ST_HDR1 : ST_OP;
      end
      ST_OP: if (rxValid) begin
        s_nxt.pktOp = rxData;
        s_nxt.sum = s_r.sum + rxData;
        s_nxt.idx = 8'h00;
        s_nxt.st = (s_r.pktLen == 8'd2) ? ST_CHK : ST_PARAM;
      end
      ST_PARAM: if (rxValid) begin
        s_nxt.params[s_r.idx[$clog2(PARAM_DEPTH)-1:0]] = rxData;
        s_nxt.sum = s_r.sum + rxData;
        s_nxt.idx = s_r.idx + 8'd1;
        if (s_r.idx + 8'd3 == s_r.pktLen) s_nxt.st = ST_CHK;
      end
      ST_CHK: if (rxValid) begin
        // corrupt or foreign packets are dropped silently
        if (rxData == checkOf(s_r.sum) &&
            (s_r.pktId == s_r.ownId || s_r.pktId == `PKT_BROADCAST_ID)) begin
          s_nxt.st = ST_EXEC;
        end else begin
          s_nxt.st = ST_HDR1;
        end
      end
      ST_EXEC: begin
        s_nxt.errByte = 8'h00;
        s_nxt.txCount = 8'h00;
        case (s_r.pktOp)
          `OP_READ: if (s_r.pktLen == `LEN_READ) s_nxt.txCount = s_r.params[1];
                    else s_nxt.errByte[`ERR_INSTR_BIT] = 1'b1;
          `OP_WRITE: s_nxt = runWrite(s_nxt, s_r.pktLen, s_r.params);
          `OP_DEFER: begin
            // a newer deferred write replaces one that is still pending
            s_nxt.deferBuf = s_r.params;
            s_nxt.deferLen = s_r.pktLen;
            s_nxt.deferPending = 1'b1;
          end
          `OP_TRIGGER: begin
            if (s_r.deferPending && s_r.pktLen == `LEN_TRIGGER) begin
              s_nxt = runWrite(s_nxt, s_r.deferLen, s_r.deferBuf);
              s_nxt.deferPending = 1'b0;
            end else begin
              s_nxt.errByte[`ERR_INSTR_BIT] = 1'b1;
            end
          end
          default: s_nxt.errByte[`ERR_INSTR_BIT] = 1'b1;
        endcase
        s_nxt.txIdx = 8'h00;
        s_nxt.st = (s_r.pktId == `PKT_BROADCAST_ID) ? ST_HDR1 : ST_TX_HDR1;
      end
      ST_TX_HDR1, ST_TX_HDR2, ST_TX_ID, ST_TX_LEN, ST_TX_ERR, ST_TX_DATA, ST_TX_CHK: begin
        // a byte is offered only when the buffer slot is free, so nothing is lost
        if (!s_r.bufValid || bufReady) begin
          s_nxt.bufData = sendByte;
          s_nxt.bufValid = 1'b1;
          case (s_r.st)
            ST_TX_HDR1: s_nxt.st = ST_TX_HDR2;
            ST_TX_HDR2: s_nxt.st = ST_TX_ID;
            ST_TX_ID: begin
              s_nxt.txSum = sendByte;
              s_nxt.st = ST_TX_LEN;
            end
            ST_TX_LEN: begin
              s_nxt.txSum = s_r.txSum + sendByte;
              s_nxt.st = ST_TX_ERR;
            end
            ST_TX_ERR: begin
              s_nxt.txSum = s_r.txSum + sendByte;
              s_nxt.st = (s_r.txCount == 8'h00) ? ST_TX_CHK : ST_TX_DATA;
            end
            ST_TX_DATA: begin
              s_nxt.txSum = s_r.txSum + sendByte;
              s_nxt.txIdx = s_r.txIdx + 8'd1;
              if (s_r.txIdx + 8'd1 == s_r.txCount) s_nxt.st = ST_TX_CHK;
            end
            default: s_nxt.st = ST_HDR1;
          endcase
        end
      end
      default: s_nxt.st = ST_HDR1;
    endcase
    // motion and drive mode follow the table every cycle
    s_nxt.endless = {s_nxt.cells[`ADR_CW_LIMIT_H], s_nxt.cells[`ADR_CW_LIMIT_L],
                     s_nxt.cells[`ADR_CCW_LIMIT_H], s_nxt.cells[`ADR_CCW_LIMIT_L]} == 32'h0;
    s_nxt.torque.dir = s_nxt.cells[`ADR_SPEED_H][2];
    s_nxt.torque.magnitude = {s_nxt.cells[`ADR_SPEED_H][1:0], s_nxt.cells[`ADR_SPEED_L]};
    s_nxt.moving = !s_nxt.endless && (goalOf(s_nxt) != presentPosition);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_r <= '0;
      // an all-zero table leaves both travel limits at zero, so endless turn starts on
      s_r.endless <= 1'b1;
      s_r.ownId <= `ID_RESET;
      s_r.cells[`ADR_TAPER_L] <= 8'(`TAPER_RESET);
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output buffer and registered outputs
  // ----------------------------------------------------------------
  // the extra output stage costs one cycle of latency but keeps every port on a flop
  assign bufOutReady = !s_r.txOutValid || txReady;

  two_entry_buffer #(.WIDTH(8), .DEPTH(2)) two_entry_buffer_inst (
    .clock(clock),
    .resetn(resetn),
    .inData(s_r.bufData),
    .inValid(s_r.bufValid),
    .inReady(bufReady),
    .outData(bufOutData),
    .outValid(bufOutValid),
    .outReady(bufOutReady)
  );

  assign txData = s_r.txOut;
  assign txValid = s_r.txOutValid;
  assign endlessTurn = s_r.endless;
  assign torqueCommand = s_r.torque;
  assign goalPosition = goalOf(s_r);
  assign taperTorque = taperOf(s_r);
  assign motionActive = s_r.moving;
endmodule // servo_packet_command_unit

/* servo_cmd_checker_assertions.sv */
/*
  Port checker for the servo packet command unit, bound to its top module.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ns
module servo_cmd_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [9:0] presentPosition,
  input wire logic endlessTurn,
  input wire logic [9:0] goalPosition,
  input wire logic [15:0] taperTorque,
  input wire logic motionActive
);
  // ----------------------------------------------------------------
  // helper: cycles since the last received byte
  // ----------------------------------------------------------------
  logic [7:0] quietCnt_r;
  always_ff @(posedge clock) begin
    if (!resetn || rxValid) begin
      quietCnt_r <= 8'h00;
    end else if (quietCnt_r != 8'hFF) begin
      quietCnt_r <= quietCnt_r + 8'h01;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_tx_hold: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("status byte dropped before acceptance");
  chk_first_header: assert property (
    $rose(txValid) |-> txData == 8'hFF)
    else $error("status packet does not open with a header byte");
  chk_second_header: assert property (
    $rose(txValid) && txReady |=> txValid && txData == 8'hFF)
    else $error("second header byte missing");
  chk_taper_reset: assert property (
    $rose(resetn) |-> taperTorque == 16'h0020)
    else $error("taper torque reset value wrong");
  chk_taper_max: assert property (
    taperTorque <= 16'h03FF)
    else $error("taper torque above its ceiling");
  // motion flag is judged only once its causes have settled for a cycle
  chk_motion_flag: assert property (
    $stable(goalPosition) && $stable(presentPosition) && $stable(endlessTurn)
    |-> motionActive == (!endlessTurn && goalPosition != presentPosition))
    else $error("motion flag disagrees with goal and position");
  chk_table_quiet: assert property (
    quietCnt_r > 8'h08 |-> $stable(taperTorque) && $stable(goalPosition))
    else $error("table output changed with no packet");
  chk_endless_quiet: assert property (
    quietCnt_r > 8'h08 |-> $stable(endlessTurn))
    else $error("endless turn changed with no packet");
  chk_tx_silence: assert property (
    quietCnt_r > 8'h64 |-> !txValid)
    else $error("status byte sent with no packet");
  cover property (txValid && !txReady);
  cover property ($fell(motionActive));
  cover property ($fell(endlessTurn));
endmodule // servo_cmd_checker

bind servo_packet_command_unit servo_cmd_checker servo_cmd_checker_inst (
  .clock(clock), .resetn(resetn), .rxValid(rxValid), .txData(txData),
  .txValid(txValid), .txReady(txReady), .presentPosition(presentPosition),
  .endlessTurn(endlessTurn), .goalPosition(goalPosition),
  .taperTorque(taperTorque), .motionActive(motionActive));

/* ctrl_model.sv */
/*
  Main controller model: frames instruction packets and collects status bytes.
  Assumes inputs change on the falling clock edge; slowMode throttles acceptance.
*/
`timescale 1ns/1ns
module ctrl_model (
  input wire logic clock,
  input wire logic slowMode,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady
);
  logic [7:0] replyQ [$];
  int phase = 0;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
  end
  always @(posedge clock) begin
    if (txValid && txReady) begin
      replyQ.push_back(txData);
    end
  end
  // slow mode takes one byte in three so the status buffer must back up
  always @(negedge clock) begin
    phase++;
    txReady <= !slowMode || (phase % 3 == 0);
  end
  task automatic send_packet(input logic [7:0] id, input logic [7:0] op, input int n,
                             input logic [7:0] p [16], input logic badSum);
    logic [7:0] f [24];
    logic [7:0] sum;
    f[0] = 8'hFF;
    f[1] = 8'hFF;
    f[2] = id;
    f[3] = 8'(n + 2);
    f[4] = op;
    sum = id + f[3] + op;
    for (int i = 0; i < n; i++) begin
      f[5 + i] = p[i];
      sum += p[i];
    end
    f[5 + n] = ~sum ^ {7'h00, badSum};
    for (int i = 0; i < n + 6; i++) begin
      @(negedge clock);
      rxValid = 1'b1;
      rxData = f[i];
    end
    @(negedge clock);
    rxValid = 1'b0;
    rxData = ~f[5 + n];
  endtask
endmodule // ctrl_model

/* tb.sv */
/*
  Self-checking testbench of the servo packet command unit.
  Assumes the package, the constants header and the controller model.
*/
`timescale 1ns/1ns
`include "servo_cmd_regs.svh"
module tb;
  import servo_cmd_pkg::*;
  logic clock, resetn, rxValid, txValid, txReady, stalled, endlessTurn, motionActive, slowMode;
  logic [7:0] rxData, txData, volts, temp;
  logic [9:0] position, goalPosition;
  logic [10:0] load;
  logic [15:0] taperTorque;
  torqueCmd_t torqueCommand;
  logic [7:0] pb [16];
  logic [7:0] db [16];
  int errors, n_tests;
  servo_packet_command_unit servo_packet_command_unit_inst (
    .clock(clock), .resetn(resetn), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .supplyVoltageTenths(volts), .temperatureCelsius(temp), .presentPosition(position),
    .stalledAtFullTorque(stalled), .measuredLoad(load), .endlessTurn(endlessTurn),
    .torqueCommand(torqueCommand), .goalPosition(goalPosition),
    .taperTorque(taperTorque), .motionActive(motionActive));
  ctrl_model ctrl_model_inst (.clock(clock), .slowMode(slowMode), .rxData(rxData),
    .rxValid(rxValid), .txData(txData), .txValid(txValid), .txReady(txReady));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // nd < 0 means no reply may come; otherwise nd data bytes from db are expected
  task automatic cmd(input logic [7:0] id, input logic [7:0] op, input int n,
                     input logic [7:0] err, input int nd, input logic bad);
    logic [7:0] q [$];
    logic [7:0] sum;
    int k;
    ctrl_model_inst.replyQ.delete();
    ctrl_model_inst.send_packet(id, op, n, pb, bad);
    k = 0;
    while (ctrl_model_inst.replyQ.size() < nd + 6 && k < 80) begin
      @(negedge clock);
      k++;
    end
    q = ctrl_model_inst.replyQ;
    if (nd < 0) begin
      check(q.size(), 32'h0);
    end else begin
      sum = id + 8'(nd + 2) + err;
      check({q[0], q[1]}, 32'hFFFF);
      check({q[2], q[3], q[4]}, {id, 8'(nd + 2), err});
      for (int i = 0; i < nd; i++) begin
        check(q[5 + i], db[i]);
        sum += db[i];
      end
      check(q[5 + nd], 8'(~sum));
    end
  endtask
  task automatic rd(input logic [7:0] id, input logic [7:0] adr, input int cnt);
    pb[0] = adr;
    pb[1] = 8'(cnt);
    cmd(id, `OP_READ, 2, 8'h00, cnt, 1'b0);
  endtask
  task automatic wr(input logic [7:0] id, input logic [7:0] adr, input logic [7:0] b0,
                    input logic [7:0] b1);
    pb[0] = adr;
    pb[1] = b0;
    pb[2] = b1;
    cmd(id, `OP_WRITE, 3, 8'h00, (id == 8'hFE) ? -1 : 0, 1'b0);
  endtask
  task automatic final_report;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    n_tests = 0;
    resetn = 1'b0;
    slowMode = 1'b0;
    volts = 8'h64;
    temp = 8'h20;
    position = 10'h000;
    stalled = 1'b0;
    load = 11'h000;
    repeat (5) @(negedge clock);
    resetn = 1'b1;
    @(negedge clock);
    check(taperTorque, 32'h20);
    check(endlessTurn, 32'h1);
    db[0] = 8'h64;
    db[1] = 8'h20;
    rd(8'h01, 8'h2A, 2);
    slowMode = 1'b1;
    db[0] = 8'h20;
    db[1] = 8'h00;
    rd(8'h01, 8'h30, 2);
    slowMode = 1'b0;
    wr(8'h01, 8'h30, 8'hE8, 8'h03);
    check(taperTorque, 32'h3E8);
    wr(8'h01, 8'h20, 8'hFF, 8'h05);
    check(torqueCommand, 32'h5FF);
    wr(8'h01, 8'h20, 8'h00, 8'h02);
    check(torqueCommand, 32'h200);
    wr(8'h01, 8'h1E, 8'h00, 8'h02);
    check({goalPosition, motionActive}, {10'h200, 1'b0});
    wr(8'h01, 8'h06, 8'h01, 8'h00);
    check({endlessTurn, motionActive}, 32'h1);
    db[0] = 8'h01;
    rd(8'h01, 8'h2E, 1);
    position = 10'h200;
    repeat (3) @(negedge clock);
    check(motionActive, 32'h0);
    stalled = 1'b1;
    load = 11'h412;
    db[0] = 8'hFF;
    db[1] = 8'h07;
    rd(8'h01, 8'h28, 2);
    pb[0] = 8'h30;
    pb[1] = 8'h40;
    pb[2] = 8'h00;
    cmd(8'h01, `OP_DEFER, 3, 8'h00, 0, 1'b0);
    check(taperTorque, 32'h3E8);
    db[0] = 8'h01;
    rd(8'h01, 8'h2C, 1);
    cmd(8'hFE, `OP_TRIGGER, 0, 8'h00, -1, 1'b0);
    check(taperTorque, 32'h40);
    db[0] = 8'h00;
    rd(8'h01, 8'h2C, 1);
    cmd(8'h01, `OP_TRIGGER, 0, 8'h40, 0, 1'b0);
    cmd(8'h01, 8'h07, 0, 8'h40, 0, 1'b0);
    pb[0] = 8'h2A;
    pb[1] = 8'h01;
    cmd(8'h01, `OP_READ, 2, 8'h00, -1, 1'b1);
    wr(8'hFE, 8'h03, 8'h05, 8'h00);
    pb[0] = 8'h2A;
    cmd(8'h01, `OP_READ, 2, 8'h00, -1, 1'b0);
    db[0] = 8'h64;
    rd(8'h05, 8'h2A, 1);
    wr(8'hFE, 8'h2F, 8'h01, 8'h00);
    wr(8'hFE, 8'h30, 8'h10, 8'h00);
    check(taperTorque, 32'h40);
    wr(8'hFE, 8'h2F, 8'h00, 8'h00);
    db[0] = 8'h01;
    rd(8'h05, 8'h2F, 1);
    wr(8'hFE, 8'h20, 8'hFF, 8'h03);
    check(torqueCommand, 32'h3FF);
    final_report;
  end
  // whole run is about a thousand cycles; this bound only cuts a hang
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    final_report;
  end
endmodule // tb
